// ---- common/upo_defs.svh ----
`ifndef UPO_DEFS_SVH
`define UPO_DEFS_SVH

// Register word offsets
`define UPO_OFS_PHIGH    12'h000
`define UPO_OFS_PLOW     12'h004
`define UPO_OFS_CTRL     12'h008
`define UPO_OFS_STATUS   12'h00C

// Field positions
`define UPO_PHIGH_BIT    0
`define UPO_CTRL_MODE_LO 0
`define UPO_CTRL_MODE_HI 2
`define UPO_STAT_HOLD    0
`define UPO_STAT_COUNT   1
`define UPO_STAT_CNT_LO  16
`define UPO_STAT_CNT_HI  24

// Reset values
`define UPO_RST_PHIGH    1'h0
`define UPO_RST_PLOW     8'h00
`define UPO_RST_MODE     3'h0

// Widths
`define UPO_P1_W         9
`define UPO_PID_W        6

`endif

// ---- common/upo_pkg.sv ----
package upo_pkg;

   typedef enum logic [2:0]
   {
      UPO_MODE_ASYNC = 3'h0,
      UPO_MODE_ADDR  = 3'h1,
      UPO_MODE_LIN   = 3'h2,
      UPO_MODE_DMX   = 3'h3,
      UPO_MODE_DEV   = 3'h4,
      UPO_MODE_GEAR  = 3'h5,
      UPO_MODE_RSV6  = 3'h6,
      UPO_MODE_RSV7  = 3'h7
   } upo_mode_t;

   typedef enum logic [2:0]
   {
      UPO_ST_IDLE  = 3'h1,
      UPO_ST_WAIT  = 3'h2,
      UPO_ST_COUNT = 3'h4
   } upo_state_t;

endpackage : upo_pkg

// ---- common/upo_tmr_if.sv ----
`timescale 1ns/1ns
interface upo_tmr_if #(parameter int W = 9);
   logic         load;
   logic [W-1:0] loadVal;
   logic         abort;
   logic         tick;
   logic         busy;
   logic         done;

   modport ctl (output load, output loadVal, output abort, output tick,
                input busy, input done);
   modport tmr (input load, input loadVal, input abort, input tick,
                output busy, output done);
endinterface : upo_tmr_if

// ---- core/upo_halfbit_timer.sv ----
`timescale 1ns/1ns
module upo_halfbit_timer #(
   parameter int W = 9
)(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // Control side
   upo_tmr_if.tmr    t
);
   import upo_pkg::*;

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         busy_r;
   logic         busy_nxt;
   logic         done_r;
   logic         done_nxt;

   generate
      if (W < 2 || W > 16)
      begin : g_bad_w
         $error("upo_halfbit_timer: W out of range");
      end
   endgenerate

   // Countdown of half-bit ticks
   always_comb
   begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (t.abort)
      begin
         cnt_nxt  = '0;
         busy_nxt = 1'b0;
      end
      else if (t.load)
      begin
         cnt_nxt  = t.loadVal;
         busy_nxt = (t.loadVal != '0);
         done_nxt = (t.loadVal == '0);
      end
      else if (busy_r && t.tick)
      begin
         cnt_nxt = cnt_r - W'(1);
         if (cnt_r == W'(1))
         begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign t.busy = busy_r;
   assign t.done = done_r;

endmodule : upo_halfbit_timer

// ---- core/upo_param_one.sv ----
`timescale 1ns/1ns
`include "upo_defs.svh"
module upo_param_one (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_b,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Events from the rest of the UART
   input  wire logic              halfBitTick,
   input  wire logic              txLastStop,
   input  wire logic              fwdFrameEnd,
   input  wire logic              backFrameEnd,
   input  wire logic              startCodeSent,
   input  wire logic              byteSent,
   // Controls to the transmitter
   output logic                   txHold,
   output logic                   breakReq,
   output logic [`UPO_PID_W-1:0]  pidOut,
   output logic [`UPO_P1_W-1:0]   addrChar
);
   import upo_pkg::*;

   upo_tmr_if #(.W(`UPO_P1_W)) tmrIf ();

   logic                  pHigh_r;
   logic                  pHigh_nxt;
   logic [7:0]            pLow_r;
   logic [7:0]            pLow_nxt;
   upo_mode_t             mode_r;
   upo_mode_t             mode_nxt;
   logic [31:0]           prdata_r;
   logic [31:0]           prdata_nxt;
   logic                  pready_r;
   logic                  pready_nxt;
   logic                  pslverr_r;
   logic                  pslverr_nxt;
   upo_state_t            state_r;
   upo_state_t            state_nxt;
   logic [`UPO_P1_W-1:0]  dmxCnt_r;
   logic [`UPO_P1_W-1:0]  dmxCnt_nxt;
   logic                  txHold_r;
   logic                  txHold_nxt;
   logic                  breakReq_r;
   logic                  breakReq_nxt;
   logic [`UPO_PID_W-1:0] pidOut_r;
   logic [`UPO_PID_W-1:0] pidOut_nxt;
   logic [`UPO_P1_W-1:0]  addrChar_r;
   logic [`UPO_P1_W-1:0]  addrChar_nxt;
   logic [`UPO_P1_W-1:0]  paramOne;
   logic                  setupPh;
   logic                  accessPh;
   logic                  mapped;
   logic [31:0]           readMux;
   logic                  modeChg;
   logic                  tmrLoad;

   assign paramOne = {pHigh_r, pLow_r};

   assign setupPh  = psel && !penable;
   assign accessPh = psel && penable && pready_r;

   // Address decode and read data
   always_comb
   begin
      mapped  = 1'b1;
      readMux = 32'h0000_0000;
      unique case (paddr)
         `UPO_OFS_PHIGH:
         begin
            readMux[`UPO_PHIGH_BIT] = pHigh_r;
         end
         `UPO_OFS_PLOW:
         begin
            readMux[7:0] = pLow_r;
         end
         `UPO_OFS_CTRL:
         begin
            readMux[`UPO_CTRL_MODE_HI:`UPO_CTRL_MODE_LO] = mode_r;
         end
         `UPO_OFS_STATUS:
         begin
            readMux[`UPO_STAT_HOLD]  = txHold_r;
            readMux[`UPO_STAT_COUNT] = (state_r == UPO_ST_COUNT);
            readMux[`UPO_STAT_CNT_HI:`UPO_STAT_CNT_LO] = dmxCnt_r;
         end
         default:
         begin
            mapped = 1'b0;
         end
      endcase
   end

   // APB answer and register writes
   always_comb
   begin
      pready_nxt  = setupPh;
      pslverr_nxt = setupPh && !mapped;
      prdata_nxt  = prdata_r;
      pHigh_nxt   = pHigh_r;
      pLow_nxt    = pLow_r;
      mode_nxt    = mode_r;
      if (setupPh)
      begin
         prdata_nxt = pwrite ? 32'h0000_0000 : readMux;
      end
      if (accessPh && pwrite)
      begin
         unique case (paddr)
            `UPO_OFS_PHIGH:
            begin
               pHigh_nxt = pwdata[`UPO_PHIGH_BIT];
            end
            `UPO_OFS_PLOW:
            begin
               pLow_nxt = pwdata[7:0];
            end
            `UPO_OFS_CTRL:
            begin
               mode_nxt = upo_mode_t'(pwdata[`UPO_CTRL_MODE_HI:`UPO_CTRL_MODE_LO]);
            end
            default:
            begin
            end
         endcase
      end
   end

   assign modeChg = (mode_nxt != mode_r);

   // Mode-dependent sequencing
   always_comb
   begin
      state_nxt    = state_r;
      dmxCnt_nxt   = dmxCnt_r;
      breakReq_nxt = 1'b0;
      tmrLoad      = 1'b0;
      unique case (state_r)
         UPO_ST_IDLE:
         begin
            if (mode_r == UPO_MODE_GEAR && fwdFrameEnd)
            begin
               tmrLoad   = 1'b1;
               state_nxt = UPO_ST_WAIT;
            end
            else if (mode_r == UPO_MODE_DEV && txLastStop)
            begin
               tmrLoad   = 1'b1;
               state_nxt = UPO_ST_WAIT;
            end
            else if (mode_r == UPO_MODE_DMX && startCodeSent)
            begin
               dmxCnt_nxt = paramOne;
               if (paramOne == '0)
               begin
                  breakReq_nxt = 1'b1;
               end
               else
               begin
                  state_nxt = UPO_ST_COUNT;
               end
            end
         end
         UPO_ST_WAIT:
         begin
            if (mode_r == UPO_MODE_DEV && backFrameEnd)
            begin
               tmrLoad = 1'b1;
            end
            else if (mode_r == UPO_MODE_GEAR && fwdFrameEnd)
            begin
               tmrLoad = 1'b1;
            end
            else if (tmrIf.done)
            begin
               state_nxt = UPO_ST_IDLE;
            end
         end
         UPO_ST_COUNT:
         begin
            if (byteSent)
            begin
               dmxCnt_nxt = dmxCnt_r - `UPO_P1_W'(1);
               if (dmxCnt_r == `UPO_P1_W'(1))
               begin
                  breakReq_nxt = 1'b1;
                  state_nxt    = UPO_ST_IDLE;
               end
            end
         end
         default:
         begin
            state_nxt = UPO_ST_IDLE;
         end
      endcase
      if (modeChg)
      begin
         state_nxt    = UPO_ST_IDLE;
         tmrLoad      = 1'b0;
         breakReq_nxt = 1'b0;
      end
   end

   // Timer hookup
   assign tmrIf.load    = tmrLoad;
   assign tmrIf.loadVal = paramOne;
   assign tmrIf.abort   = modeChg;
   assign tmrIf.tick    = halfBitTick;

   // Transmitter controls
   always_comb
   begin
      txHold_nxt   = (state_nxt == UPO_ST_WAIT);
      pidOut_nxt   = '0;
      addrChar_nxt = '0;
      if (mode_r == UPO_MODE_LIN)
      begin
         pidOut_nxt = paramOne[`UPO_PID_W-1:0];
      end
      if (mode_r == UPO_MODE_ADDR)
      begin
         addrChar_nxt = {1'b1, pLow_r};
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pHigh_r    <= `UPO_RST_PHIGH;
         pLow_r     <= `UPO_RST_PLOW;
         mode_r     <= upo_mode_t'(`UPO_RST_MODE);
         prdata_r   <= 32'h0000_0000;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         state_r    <= UPO_ST_IDLE;
         dmxCnt_r   <= '0;
         txHold_r   <= 1'b0;
         breakReq_r <= 1'b0;
         pidOut_r   <= '0;
         addrChar_r <= '0;
      end
      else
      begin
         pHigh_r    <= pHigh_nxt;
         pLow_r     <= pLow_nxt;
         mode_r     <= mode_nxt;
         prdata_r   <= prdata_nxt;
         pready_r   <= pready_nxt;
         pslverr_r  <= pslverr_nxt;
         state_r    <= state_nxt;
         dmxCnt_r   <= dmxCnt_nxt;
         txHold_r   <= txHold_nxt;
         breakReq_r <= breakReq_nxt;
         pidOut_r   <= pidOut_nxt;
         addrChar_r <= addrChar_nxt;
      end
   end

   assign prdata   = prdata_r;
   assign pready   = pready_r;
   assign pslverr  = pslverr_r;
   assign txHold   = txHold_r;
   assign breakReq = breakReq_r;
   assign pidOut   = pidOut_r;
   assign addrChar = addrChar_r;

   upo_halfbit_timer #(
      .W     (`UPO_P1_W)
   ) uTimer (
      .mclk  (mclk),
      .rst_b (rst_b),
      .t     (tmrIf.tmr)
   );

endmodule : upo_param_one

// ---- verif/upo_peer_model.sv ----
`timescale 1ns/1ns
module upo_peer_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // Pace control
   input  wire logic       run,
   input  wire logic [3:0] per,
   // Half-bit pace
   output logic            halfBitTick
);
   logic [3:0] cnt_r;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_r <= 4'h0;
      else
         cnt_r <= (!run || cnt_r == per - 4'h1) ? 4'h0 : cnt_r + 4'h1;
   end
   assign halfBitTick = run && (cnt_r == per - 4'h1);
endmodule : upo_peer_model

// ---- verif/upo_param_one_chk.sv ----
`timescale 1ns/1ns
`include "upo_defs.svh"
module upo_param_one_chk (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_b,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Events
   input wire logic        txLastStop,
   input wire logic        fwdFrameEnd,
   input wire logic        startCodeSent,
   input wire logic        byteSent,
   // Controls
   input wire logic        txHold,
   input wire logic        breakReq,
   input wire logic [5:0]  pidOut,
   input wire logic [8:0]  addrChar
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_rdy_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_rdy_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_rd_high_zero: assert property (pready && !pwrite && paddr == `UPO_OFS_PHIGH
      |-> prdata[31:1] == 31'h0) else $error("high register upper bits set");
   a_rd_low_byte: assert property (pready && !pwrite && paddr == `UPO_OFS_PLOW
      |-> prdata[31:8] == 24'h0) else $error("low register upper bits set");
   a_pid_follow: assert property ($changed(pidOut) |-> $past(pready && pwrite, 2))
      else $error("identifier changed without write");
   a_addr_follow: assert property ($changed(addrChar) |-> $past(pready && pwrite, 2))
      else $error("address changed without write");
   a_addr_ninth: assert property (addrChar != 9'h0 |-> addrChar[8])
      else $error("address ninth bit clear");
   a_brk_cause: assert property (breakReq |-> $past(byteSent || startCodeSent) ##1 !breakReq)
      else $error("break without cause");
   a_hold_cause: assert property ($rose(txHold) |-> $past(txLastStop || fwdFrameEnd))
      else $error("hold without frame end");
   c_brk: cover property (breakReq);
   c_hold: cover property ($rose(txHold));
   c_err: cover property (pready && pslverr);
endmodule : upo_param_one_chk

bind upo_param_one upo_param_one_chk i_upo_param_one_chk (.mclk(mclk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .txLastStop(txLastStop), .fwdFrameEnd(fwdFrameEnd),
   .startCodeSent(startCodeSent), .byteSent(byteSent), .txHold(txHold),
   .breakReq(breakReq), .pidOut(pidOut), .addrChar(addrChar));

// ---- verif/upo_param_one_test.sv ----
`timescale 1ns/1ns
`include "upo_defs.svh"
module upo_param_one_test;
   logic        mclk, rst_b, psel, penable, pwrite, run, pready, pslverr, txHold, breakReq;
   logic        tick, lastErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, w1, w2;
   logic [4:0]  ev;
   logic [3:0]  per;
   logic [5:0]  pidOut;
   logic [8:0]  addrChar;
   logic [31:0] seed = 32'h050F;
   int          failures = 0, comparisons = 0, holdCnt = 0, brkCnt = 0, h0, n;

   upo_param_one i_upo_param_one (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .halfBitTick(tick), .txLastStop(ev[0]),
      .fwdFrameEnd(ev[1]), .backFrameEnd(ev[2]), .startCodeSent(ev[3]), .byteSent(ev[4]),
      .txHold(txHold), .breakReq(breakReq), .pidOut(pidOut), .addrChar(addrChar));
   upo_peer_model i_upo_peer_model (.mclk(mclk), .rst_b(rst_b), .run(run), .per(per),
      .halfBitTick(tick));

   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function int hold_len(input int cnt, input int p);
      return (cnt == 0) ? 1 : cnt * p;
   endfunction : hold_len

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task pulse(input logic [4:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 5'h00;
   endtask : pulse

   task close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   always @(posedge mclk)
   begin
      if (txHold === 1'b1)
         holdCnt <= holdCnt + 1;
      if (breakReq === 1'b1)
         brkCnt <= brkCnt + 1;
   end

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      close_out();
   end

   initial
   begin
      {psel, penable, pwrite, run, ev, paddr, pwdata, per} = '0;
      rst_b = 1'b0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, `UPO_OFS_PHIGH, 32'h0, rd);
      check(rd, 32'h0);
      apb(1'b0, `UPO_OFS_PLOW, 32'h0, rd);
      check(rd, 32'h0);
      for (int m = 0; m < 8; m++)
      begin
         w1 = xs();
         w2 = xs();
         apb(1'b1, `UPO_OFS_CTRL, m, rd);
         apb(1'b1, `UPO_OFS_PHIGH, w1, rd);
         apb(1'b1, `UPO_OFS_PLOW, w2, rd);
         apb(1'b0, `UPO_OFS_PHIGH, 32'h0, rd);
         check(rd, {31'h0, w1[0]});
         apb(1'b0, `UPO_OFS_PLOW, 32'h0, rd);
         check(rd, {24'h0, w2[7:0]});
         check(pidOut, (m == 2) ? w2[5:0] : 6'h0);
         check(addrChar, (m == 1) ? {1'b1, w2[7:0]} : 9'h0);
      end
      apb(1'b1, 12'h010, 32'hFFFF_FFFF, rd);
      check(lastErr, 1'b1);
      apb(1'b0, `UPO_OFS_PLOW, 32'h0, rd);
      check(rd, {24'h0, w2[7:0]});
      n = (xs() % 3) + 1;
      apb(1'b1, `UPO_OFS_CTRL, 32'h3, rd);
      apb(1'b1, `UPO_OFS_PHIGH, 32'h0, rd);
      apb(1'b1, `UPO_OFS_PLOW, n, rd);
      h0 = brkCnt;
      pulse(5'h08);
      repeat (n - 1) pulse(5'h10);
      repeat (2) @(posedge mclk);
      check(brkCnt - h0, 0);
      pulse(5'h10);
      repeat (2) @(posedge mclk);
      check(brkCnt - h0, 1);
      apb(1'b1, `UPO_OFS_PLOW, 32'h0, rd);
      pulse(5'h08);
      repeat (2) @(posedge mclk);
      check(brkCnt - h0, 2);
      for (int k = 0; k < 5; k++)
      begin
         n = (k == 4) ? 256 : k;
         apb(1'b1, `UPO_OFS_CTRL, 4 + (k & 1), rd);
         apb(1'b1, `UPO_OFS_PHIGH, n >> 8, rd);
         apb(1'b1, `UPO_OFS_PLOW, n, rd);
         h0 = holdCnt;
         @(posedge mclk);
         ev <= (k & 1) ? 5'h02 : 5'h01;
         run <= 1'b1;
         per <= 4'h2 + 4'(xs() & 32'h3);
         @(posedge mclk);
         ev <= 5'h00;
         repeat (n * 5 + 4) @(posedge mclk);
         run <= 1'b0;
         repeat (2) @(posedge mclk);
         check(holdCnt - h0, hold_len(n, per));
      end
      // Backward frame restarts the idle wait
      apb(1'b1, `UPO_OFS_PHIGH, 32'h0, rd);
      apb(1'b1, `UPO_OFS_PLOW, 32'h2, rd);
      h0 = holdCnt;
      pulse(5'h01);
      repeat (3) @(posedge mclk);
      ev <= 5'h04;
      run <= 1'b1;
      per <= 4'h3;
      @(posedge mclk);
      ev <= 5'h00;
      repeat (12) @(posedge mclk);
      run <= 1'b0;
      repeat (2) @(posedge mclk);
      check(holdCnt - h0, 4 + hold_len(2, 3));
      // Mid-run reset clears the stored value
      apb(1'b1, `UPO_OFS_PHIGH, 32'h1, rd);
      apb(1'b1, `UPO_OFS_PLOW, 32'hA5, rd);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, `UPO_OFS_PHIGH, 32'h0, rd);
      check(rd, 32'h0);
      apb(1'b0, `UPO_OFS_PLOW, 32'h0, rd);
      check(rd, 32'h0);
      close_out();
   end
endmodule : upo_param_one_test
